/* File: rtl/sirq_consts.svh */
// Constants of the serialized interrupt slave: frame timing and enable bit positions.
// Included by the package and the slave module.
`ifndef SIRQ_CONSTS_SVH
`define SIRQ_CONSTS_SVH
`define SIRQ_NUM_FRAMES 16
`define SIRQ_SLOT_LAST 47
// First count at which a low line can only be the stop pulse: the echo of the
// last slot drive through the input synchroniser has passed by then
`define SIRQ_STOP_FROM 50
`define SIRQ_SLOT_W 6
`define SIRQ_MGMT_FRAME 3
`define SIRQ_STOP_QUIET_LEN 2
`define SIRQ_STOP_CONT_LEN 3
`define SIRQ_STOP_MAX_LEN 3
`define SIRQ_START_GAP 2
`define SIRQ_EN_SERIAL_BIT 6
`define SIRQ_EN_PIN_BIT 7
`define SIRQ_MODE_RESET 1'b1
`endif

/* File: rtl/sirq_pkg.sv */
// Types of the serialized interrupt slave.
// Constants live in sirq_consts.svh.
`include "sirq_consts.svh"
package sirq_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA = 5'b00100,
    ST_STOP = 5'b01000,
    ST_GAP = 5'b10000
  } sirq_state_e;

  typedef struct packed {
    logic out;
    logic oe;
  } sirq_pin_s;

  typedef struct packed {
    logic [15:0] levels;
    logic [15:0] last;
    logic change;
  } sirq_src_s;
endpackage

/* File: rtl/sirq_sync.sv */
// Two-flop synchroniser, one per bit.
// Assumes ref_clk_i and an enable that freezes both stages.
`timescale 1ns/1ps
module sirq_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sirq_sync_s;
  sirq_sync_s st_reg;
  sirq_sync_s st_next;

  always_comb begin
    st_next = st_reg;
    if (ce_i) begin
      st_next.s1 = d_i;
      st_next.s2 = st_reg.s1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;
endmodule // sirq_sync

/* File: rtl/sirq_src.sv */
// Interrupt source sampler: holds the latest level per frame and flags any change.
// Assumes synchronised levels; index 0 is the unused frame, kept high.
`timescale 1ns/1ps
module sirq_src (
  // Clock
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Levels
  input wire logic [15:0] lvl_i,
  input wire logic change_clr_i,
  output sirq_pkg::sirq_src_s src_o
);
  sirq_pkg::sirq_src_s st_reg;
  sirq_pkg::sirq_src_s st_next;
  logic [15:0] diff;

  always_comb begin
    st_next = st_reg;
    diff = '0;
    if (ce_i) begin
      st_next.levels = lvl_i;
      st_next.last = st_reg.levels;
      diff = st_reg.levels ^ st_reg.last;
      // A fresh edge beats the clear so no change is lost
      if (|diff) begin
        st_next.change = 1'b1;
      end else if (change_clr_i) begin
        st_next.change = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_reg <= '{levels: 16'hffff, last: 16'hffff, change: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign src_o = st_reg;
endmodule // sirq_src

/* File: rtl/sirq_slave.sv */
// Serialized interrupt slave agent: reports interrupt levels in their frame slots.
// Assumes one clock domain (bus clock); the line is open, resolved outside.
`timescale 1ns/1ps
`include "sirq_consts.svh"
module sirq_slave (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Serial interrupt line
  input wire logic sirq_line_i,
  output logic sirq_line_o,
  output logic sirq_line_oe_o,
  // Interrupt sources, active high request lines 1..15
  input wire logic [15:1] irq_i,
  input wire logic system_mgmt_interrupt_n_i,
  input wire logic [7:0] mgmt_enable2_i,
  // Management pin and status
  output logic mgmt_interrupt_out_pin_n_o,
  output logic quiet_mode_o,
  output logic cycle_active_o
);
  typedef struct packed {
    sirq_pkg::sirq_state_e state;
    logic quiet;
    logic [`SIRQ_SLOT_W-1:0] cnt;
    logic [1:0] phase;
    logic [4:0] frame;
    logic drove_low;
    logic [2:0] low_len;
    logic prev_line;
    logic orig;
    sirq_pkg::sirq_pin_s pin;
    logic mgmt_pin_n;
    logic active;
  } sirq_st_s;

  sirq_st_s st_reg;
  sirq_st_s st_next;
  logic line_s;
  logic [16:0] raw_s;
  logic [15:0] lvl;
  logic chg_clr;
  sirq_pkg::sirq_src_s src;

  // Line and all pins come from outside the clock domain; the line and the
  // management input pass inverted so the cleared stages read as idle-high
  sirq_sync #(.W(17)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({~sirq_line_i, ~system_mgmt_interrupt_n_i, irq_i}),
    .q_o(raw_s)
  );

  assign line_s = ~raw_s[16];

  // Frame slot levels: low means asserted on the line
  always_comb begin
    lvl = '1;
    for (int i = 1; i < `SIRQ_NUM_FRAMES; i++) begin
      lvl[i] = ~raw_s[i - 1];
    end
    // Both sources may share the slot; software keeps one masked
    if (mgmt_enable2_i[`SIRQ_EN_SERIAL_BIT] && raw_s[15]) begin
      lvl[`SIRQ_MGMT_FRAME - 1] = 1'b0;
    end
  end

  sirq_src u_src (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .lvl_i(lvl),
    .change_clr_i(chg_clr),
    .src_o(src)
  );

  // Change is delivered by a running cycle once its frame is still ahead
  assign chg_clr = st_reg.state == sirq_pkg::ST_START && line_s && !st_reg.prev_line;

  always_comb begin
    st_next = st_reg;
    st_next.pin = '{out: 1'b1, oe: 1'b0};
    st_next.mgmt_pin_n = ~(mgmt_enable2_i[`SIRQ_EN_PIN_BIT] & raw_s[15]);
    if (ce_i) begin
      st_next.prev_line = line_s;
      unique case (st_reg.state)
        sirq_pkg::ST_IDLE: begin
          st_next.orig = 1'b0;
          if (!line_s) begin
            st_next.state = sirq_pkg::ST_START;
          end else if (st_reg.quiet && src.change && !st_reg.orig) begin
            st_next.pin = '{out: 1'b0, oe: 1'b1};
            st_next.orig = 1'b1;
            st_next.state = sirq_pkg::ST_START;
          end
        end
        sirq_pkg::ST_START: begin
          // Released after one low clock; host holds the rest of the pulse
          st_next.orig = 1'b0;
          // Only a rising edge ends the pulse; our own low is still in the synchroniser
          if (line_s && !st_reg.prev_line) begin
            st_next.state = sirq_pkg::ST_DATA;
            st_next.cnt = `SIRQ_SLOT_W'(1);
            st_next.phase = 2'd0;
            st_next.frame = 5'd0;
          end
        end
        sirq_pkg::ST_DATA: begin
          st_next.cnt = st_reg.cnt + `SIRQ_SLOT_W'(1);
          if (st_reg.phase == 2'd2) begin
            st_next.phase = 2'd0;
            st_next.frame = st_reg.frame + 5'd1;
          end else begin
            st_next.phase = st_reg.phase + 2'd1;
          end
          // Next clock is the sample of frame n when cnt+1 = 3n+2
          if (st_reg.phase == 2'd0 && st_reg.frame < 5'(`SIRQ_NUM_FRAMES)) begin
            if (!src.levels[st_reg.frame[3:0]]) begin
              st_next.pin = '{out: 1'b0, oe: 1'b1};
              st_next.drove_low = 1'b1;
            end else begin
              st_next.drove_low = 1'b0;
            end
          end else if (st_reg.phase == 2'd1) begin
            if (st_reg.drove_low) begin
              st_next.pin = '{out: 1'b1, oe: 1'b1};
            end
            st_next.drove_low = 1'b0;
          end
          // Stop pulse may start in any phase, so every low clock is counted
          if (st_reg.cnt >= `SIRQ_SLOT_W'(`SIRQ_STOP_FROM) && !line_s) begin
            st_next.state = sirq_pkg::ST_STOP;
            st_next.low_len = 3'd1;
          end
        end
        sirq_pkg::ST_STOP: begin
          if (!line_s) begin
            if (st_reg.low_len < 3'(`SIRQ_STOP_MAX_LEN)) begin
              st_next.low_len = st_reg.low_len + 3'd1;
            end
          end else begin
            // Mode is taken only from the stop pulse width
            st_next.quiet = st_reg.low_len == 3'(`SIRQ_STOP_QUIET_LEN);
            st_next.state = sirq_pkg::ST_GAP;
            st_next.cnt = '0;
          end
        end
        sirq_pkg::ST_GAP: begin
          st_next.cnt = st_reg.cnt + `SIRQ_SLOT_W'(1);
          if (!line_s) begin
            st_next.state = sirq_pkg::ST_START;
          end else if (st_reg.cnt + `SIRQ_SLOT_W'(1) >= `SIRQ_SLOT_W'(`SIRQ_START_GAP - 1)) begin
            st_next.state = sirq_pkg::ST_IDLE;
          end
        end
        default: begin
          st_next.state = sirq_pkg::ST_IDLE;
        end
      endcase
    end else begin
      st_next.pin = st_reg.pin;
      st_next.mgmt_pin_n = st_reg.mgmt_pin_n;
    end
    st_next.active = st_next.state != sirq_pkg::ST_IDLE;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_reg <= '{state: sirq_pkg::ST_IDLE, quiet: ~`SIRQ_MODE_RESET, cnt: '0,
                  phase: '0, frame: '0, drove_low: 1'b0, low_len: '0,
                  prev_line: 1'b1, orig: 1'b0, pin: '{out: 1'b1, oe: 1'b0},
                  mgmt_pin_n: 1'b1, active: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sirq_line_o = st_reg.pin.out;
  assign sirq_line_oe_o = st_reg.pin.oe;
  assign mgmt_interrupt_out_pin_n_o = st_reg.mgmt_pin_n;
  assign quiet_mode_o = st_reg.quiet;
  assign cycle_active_o = st_reg.active;
endmodule // sirq_slave

/* File: test/sirq_slave_props.sv */
// Checker for the serial interrupt slave, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module sirq_slave_props (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Line and sources
  input wire logic sirq_line_o,
  input wire logic sirq_line_oe_o,
  input wire logic system_mgmt_interrupt_n_i,
  input wire logic [7:0] mgmt_enable2_i,
  // Status
  input wire logic mgmt_interrupt_out_pin_n_o,
  input wire logic quiet_mode_o,
  input wire logic cycle_active_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  AST_SINGLE_LOW: assert property (
    (sirq_line_oe_o && !sirq_line_o) |=> !(sirq_line_oe_o && !sirq_line_o))
    else $error("line driven low two clocks running");
  AST_HIGH_AFTER_LOW: assert property (
    (sirq_line_oe_o && sirq_line_o) |-> $past(sirq_line_oe_o) && !$past(sirq_line_o))
    else $error("line driven high without a low before it");
  AST_TURN_RELEASE: assert property (
    (sirq_line_oe_o && sirq_line_o) |=> !sirq_line_oe_o)
    else $error("line not released after recovery");
  AST_IDLE_DRIVE: assert property (
    (sirq_line_oe_o && !$past(cycle_active_o)) |-> (quiet_mode_o && !sirq_line_o))
    else $error("line driven while idle outside quiet mode");
  AST_PIN_ON: assert property (
    (mgmt_enable2_i[7] && !system_mgmt_interrupt_n_i) [*5] |-> !mgmt_interrupt_out_pin_n_o)
    else $error("management pin not asserted");
  AST_PIN_OFF: assert property (
    (!mgmt_enable2_i[7]) [*5] |-> mgmt_interrupt_out_pin_n_o)
    else $error("management pin asserted while disabled");
  AST_RESET_STATE: assert property (disable iff (1'b0)
    rst_i |=> !sirq_line_oe_o && !quiet_mode_o && !cycle_active_o && mgmt_interrupt_out_pin_n_o)
    else $error("reset state wrong");
  AST_MODE_IN_CYCLE: assert property (
    $changed(quiet_mode_o) |-> $past(cycle_active_o))
    else $error("mode changed outside a cycle");
endmodule // sirq_slave_props
bind sirq_slave sirq_slave_props sirq_slave_props_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .sirq_line_o(sirq_line_o), .sirq_line_oe_o(sirq_line_oe_o),
  .system_mgmt_interrupt_n_i(system_mgmt_interrupt_n_i), .mgmt_enable2_i(mgmt_enable2_i),
  .mgmt_interrupt_out_pin_n_o(mgmt_interrupt_out_pin_n_o), .quiet_mode_o(quiet_mode_o),
  .cycle_active_o(cycle_active_o));

/* File: test/sirq_host_model.sv */
// Behavioural host controller for the serial interrupt line.
// Assumes a pulled-up line resolved by the testbench; acts on rising edges only.
`timescale 1ns/1ps
module sirq_host_model (
  // Clock and control
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [3:0] start_len_i,
  input wire logic [1:0] stop_len_i,
  // Line
  input wire logic line_i,
  output logic out_o,
  output logic oe_o,
  output logic busy_o
);
  task automatic hold(input logic v, input int n);
    repeat (n) begin
      out_o <= v;
      oe_o <= 1'b1;
      @(posedge ref_clk_i);
    end
  endtask
  initial begin
    out_o = 1'b1;
    oe_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge ref_clk_i);
      if (!rst_i && (go_i || !line_i)) begin
        busy_o <= 1'b1;
        hold(1'b0, start_len_i - {3'h0, !line_i});
        hold(1'b1, 1);
        oe_o <= 1'b0;
        // Slots land late by the slave's input sync, so stop well after frame 16
        repeat (54) @(posedge ref_clk_i);
        hold(1'b0, stop_len_i);
        hold(1'b1, 1);
        oe_o <= 1'b0;
        @(posedge ref_clk_i);
        busy_o <= 1'b0;
      end
    end
  end
endmodule // sirq_host_model

/* File: test/tb_top.sv */
// Self-checking bench for the serial interrupt slave against a host model.
// Assumes a pulled-up line; the clock enable is held high throughout.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0;
  logic smi_n = 1'b1;
  logic [3:0] start_len = 4'h4;
  logic [1:0] stop_len = 2'h3;
  // Source 1 stays asserted as the timing anchor of every cycle
  logic [15:1] irq = 15'h0001;
  logic [7:0] en2 = 8'h00;
  logic dev_out, dev_oe, host_out, host_oe, host_busy, pin_n, quiet, active, line;
  int seed = 45528;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int rise = 0;
  int starts = 0;
  int s0;
  int lows[$];
  always #5 ref_clk_i = ~ref_clk_i;
  assign line = (dev_oe ? dev_out : 1'b1) & (host_oe ? host_out : 1'b1);
  sirq_slave sirq_slave_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .sirq_line_i(line), .sirq_line_o(dev_out), .sirq_line_oe_o(dev_oe), .irq_i(irq),
    .system_mgmt_interrupt_n_i(smi_n), .mgmt_enable2_i(en2),
    .mgmt_interrupt_out_pin_n_o(pin_n), .quiet_mode_o(quiet), .cycle_active_o(active));
  sirq_host_model sirq_host_model_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .go_i(go),
    .start_len_i(start_len), .stop_len_i(stop_len), .line_i(line), .out_o(host_out),
    .oe_o(host_oe), .busy_o(host_busy));
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (host_busy && dev_oe && !dev_out) lows.push_back(cyc);
    if (!host_busy && dev_oe && !dev_out) starts <= starts + 1;
    if (host_busy && host_oe && host_out && rise == 0) rise <= cyc;
  end
  task automatic finish_test();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (host_busy !== v && n < 300) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 300) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic run(input logic g);
    logic [15:1] obs;
    int off;
    lows.delete();
    rise = 0;
    obs = '0;
    go = g;
    wait_busy(1'b1);
    go = 1'b0;
    wait_busy(1'b0);
    // Stop width reaches the mode flag two synchroniser clocks later
    repeat (2) @(negedge ref_clk_i);
    foreach (lows[i]) begin
      off = lows[i] - lows[0];
      if (off % 3 != 0 || off > 42) chk(16'(off), 16'h0);
      else obs[off / 3 + 1] = 1'b1;
    end
    chk({15'h0, lows[0] - rise inside {[5:10]}}, 16'h1);
    chk({2'h0, obs[15:3], obs[1]}, {2'h0, irq[15:3], 1'b1});
  endtask
  initial begin
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk({13'h0, dev_oe, quiet, active}, 16'h0);
    irq[5] = 1'b1;
    s0 = starts;
    repeat (30) @(negedge ref_clk_i);
    chk(16'(starts - s0), 16'h0);
    for (int i = 0; i < 6; i++) begin
      start_len = 4'(4 + (i * 3) % 5);
      stop_len = (i % 2 == 1) ? 2'h2 : 2'h3;
      irq = 15'($random(seed)) | 15'h0001;
      run(1'b1);
      chk({15'h0, quiet}, {15'h0, stop_len == 2'h2});
      s0 = starts;
      irq[9] = ~irq[9];
      if (quiet) begin
        run(1'b0);
        chk(16'(starts - s0), 16'h1);
      end else begin
        repeat (40) @(negedge ref_clk_i);
        chk(16'(starts - s0), 16'h0);
      end
    end
    for (int j = 0; j < 4; j++) begin
      en2 = 8'($random(seed));
      en2[7] = j[0];
      smi_n = j[1];
      repeat (6) @(negedge ref_clk_i);
      chk({15'h0, pin_n}, {15'h0, ~(j[0] & ~j[1])});
    end
    rst_i = 1'b1;
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk({13'h0, dev_oe, quiet, pin_n}, 16'h1);
    finish_test();
  end
endmodule // tb_top
